/* File: standby_touch_scan.sv */
// Standby touch scan sequencer with its configuration registers.
// Assumes an analog front end that measures one selected channel per request and
// returns one signed delta sample after the programmed sample time.
`timescale 1ns/1ns
`default_nettype none
module standby_touch_scan
	import standby_scan_pkg::*;
#(
	parameter int SAMPLE_W = 16,
	parameter int SAMPLE_BASE_CYCLES = SAMPLE_BASE_CYC,
	parameter int CYCLE_BASE_CYCLES = CYCLE_BASE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic standby_mode,
	output logic [2:0] afe_chan,
	output logic afe_sample_req,
	input wire logic afe_sample_valid,
	input wire logic signed [SAMPLE_W-1:0] afe_sample,
	output logic low_power,
	output logic [NUM_CHAN-1:0] touch_status,
	output logic touch_event
);

	localparam int SUM_W = SAMPLE_W + 8;
	localparam int SCALED_W = SUM_W + 8;
	localparam int TIMER_W = 32;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] chan_enable_q;
	logic [7:0] scan_config_q;
	logic [7:0] sensitivity_q;
	logic [7:0] threshold_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chan_enable_q <= RST_CHAN_ENABLE;
			scan_config_q <= RST_SCAN_CONFIG;
			sensitivity_q <= RST_SENSITIVITY;
			threshold_q <= RST_THRESHOLD;
		end else if (clk_en && reg_wr) begin
			case (reg_addr)
				ADDR_CHAN_ENABLE: chan_enable_q <= reg_wdata & MASK_CHAN_ENABLE;
				ADDR_SCAN_CONFIG: scan_config_q <= reg_wdata;
				ADDR_SENSITIVITY: sensitivity_q <= reg_wdata & MASK_SENSITIVITY;
				ADDR_THRESHOLD: threshold_q <= reg_wdata & MASK_THRESHOLD;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (clk_en) begin
			if (reg_rd) begin
				case (reg_addr)
					ADDR_CHAN_ENABLE: reg_rdata <= chan_enable_q;
					ADDR_SCAN_CONFIG: reg_rdata <= scan_config_q;
					ADDR_SENSITIVITY: reg_rdata <= sensitivity_q;
					ADDR_THRESHOLD: reg_rdata <= threshold_q;
					ADDR_TOUCH_STATUS: reg_rdata <= {2'b00, touch_status};
					default: reg_rdata <= 8'h00;
				endcase
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	logic accumulate_select;
	logic [2:0] standby_sample_count;
	logic [1:0] standby_sample_duration;
	logic [1:0] standby_cycle_period;
	logic [2:0] standby_gain;

	assign accumulate_select = scan_config_q[ACC_SEL_BIT];
	assign standby_sample_count = scan_config_q[COUNT_MSB:COUNT_LSB];
	assign standby_sample_duration = scan_config_q[DUR_MSB:DUR_LSB];
	assign standby_cycle_period = scan_config_q[PERIOD_MSB:PERIOD_LSB];
	assign standby_gain = sensitivity_q[2:0];

	function automatic logic [TIMER_W-1:0] sample_cycles(input logic [1:0] code);
		sample_cycles = TIMER_W'(SAMPLE_BASE_CYCLES) << code;
	endfunction

	function automatic logic [TIMER_W-1:0] period_cycles(input logic [1:0] code);
		period_cycles = TIMER_W'(CYCLE_BASE_CYCLES) * TIMER_W'({30'd0, code} + 32'd1);
	endfunction

	// Finds the next enabled channel at or above the given index.
	function automatic logic [3:0] next_chan(input logic [5:0] en, input logic [2:0] from);
		next_chan = 4'(NUM_CHAN);
		for (int i = NUM_CHAN - 1; i >= 0; i--) begin
			if (en[i] && (3'(i) >= from)) begin
				next_chan = 4'(i);
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	scan_state_e state_q;
	logic [2:0] chan_q;
	logic [7:0] samples_left_q;
	logic [TIMER_W-1:0] period_timer_q;
	logic [TIMER_W-1:0] sample_timer_q;
	logic acc_clear;
	logic [3:0] first_chan;
	logic [3:0] following_chan;
	logic signed [SUM_W-1:0] sum;
	logic [7:0] sample_total;

	assign sample_total = 8'(8'h01 << standby_sample_count);
	assign first_chan = next_chan(chan_enable_q[5:0], 3'd0);
	assign following_chan = next_chan(chan_enable_q[5:0], 3'(chan_q + 3'd1));
	assign acc_clear = (state_q != ST_SAMPLE);

	standby_sample_accum #(
		.SAMPLE_W(SAMPLE_W),
		.SUM_W(SUM_W)
	) u_accum (
		.clk(clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.clear(acc_clear),
		.sample_valid(afe_sample_valid && state_q == ST_SAMPLE),
		.sample(afe_sample),
		.sum_q(sum)
	);

	// period timer runs from cycle start
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			period_timer_q <= '0;
		end else if (clk_en) begin
			// The idle cycle is the first cycle of the period, so the count starts at one
			// there; starting at zero would stretch every period by one clock.
			if (state_q == ST_IDLE) begin
				period_timer_q <= TIMER_W'(1);
			end else if (period_timer_q != '1) begin
				period_timer_q <= period_timer_q + TIMER_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			chan_q <= 3'd0;
			samples_left_q <= 8'd0;
			sample_timer_q <= '0;
			afe_sample_req <= 1'b0;
			afe_chan <= 3'd0;
			low_power <= 1'b0;
		end else if (clk_en) begin
			afe_sample_req <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					low_power <= 1'b0;
					if (standby_mode) begin
						if (first_chan == 4'(NUM_CHAN)) begin
							state_q <= ST_REST;
							low_power <= 1'b1;
						end else begin
							chan_q <= first_chan[2:0];
							afe_chan <= first_chan[2:0];
							samples_left_q <= sample_total;
							sample_timer_q <= '0;
							state_q <= ST_SAMPLE;
						end
					end
				end
				// back to back samples on one channel
				ST_SAMPLE: begin
					if (!standby_mode) begin
						state_q <= ST_REST;
					end else if (sample_timer_q == '0) begin
						afe_sample_req <= 1'b1;
						sample_timer_q <= sample_cycles(standby_sample_duration);
					end else if (afe_sample_valid) begin
						sample_timer_q <= '0;
						samples_left_q <= samples_left_q - 8'd1;
						if (samples_left_q == 8'd1) begin
							state_q <= ST_EVAL;
						end
					end
				end
				ST_EVAL: begin
					if (following_chan == 4'(NUM_CHAN) || !standby_mode) begin
						state_q <= ST_REST;
						low_power <= standby_mode;
					end else begin
						chan_q <= following_chan[2:0];
						afe_chan <= following_chan[2:0];
						samples_left_q <= sample_total;
						state_q <= ST_SAMPLE;
					end
				end
				ST_REST: begin
					if (!standby_mode || period_timer_q >= period_cycles(standby_cycle_period) - 1) begin
						state_q <= ST_IDLE;
						low_power <= 1'b0;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Evaluation
	// ----------------------------------------------------------------
	logic signed [SUM_W-1:0] delta;
	logic signed [SCALED_W-1:0] scaled;

	assign delta = accumulate_select ? sum : (sum >>> standby_sample_count);
	// code 0 is 128x, code 7 is 1x
	assign scaled = SCALED_W'(delta) <<< (3'd7 - standby_gain);

	// The threshold is widened as a positive signed value so that a negative delta
	// never wraps into a large unsigned number and reports a false touch.
	logic over_threshold;
	assign over_threshold = scaled > $signed(SCALED_W'(threshold_q[6:0]));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			touch_status <= '0;
			touch_event <= 1'b0;
		end else if (clk_en) begin
			touch_event <= 1'b0;
			if (state_q == ST_EVAL) begin
				touch_status[chan_q] <= over_threshold;
				touch_event <= over_threshold;
			end
		end
	end

endmodule // standby_touch_scan
`default_nettype wire

/* File: standby_scan_pkg.sv */
// Package for the standby touch scan block: register map, field layout, timing constants.
// Assumes a 50 MHz system clock and byte-wide register access.
package standby_scan_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CHAN_ENABLE = 8'h40;
	localparam logic [7:0] ADDR_SCAN_CONFIG = 8'h41;
	localparam logic [7:0] ADDR_SENSITIVITY = 8'h42;
	localparam logic [7:0] ADDR_THRESHOLD = 8'h43;
	localparam logic [7:0] ADDR_TOUCH_STATUS = 8'h44;

	localparam logic [7:0] RST_CHAN_ENABLE = 8'h00;
	localparam logic [7:0] RST_SCAN_CONFIG = 8'h39;
	localparam logic [7:0] RST_SENSITIVITY = 8'h02;
	localparam logic [7:0] RST_THRESHOLD = 8'h40;

	localparam logic [7:0] MASK_CHAN_ENABLE = 8'h3f;
	localparam logic [7:0] MASK_SENSITIVITY = 8'h07;
	localparam logic [7:0] MASK_THRESHOLD = 8'h7f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ACC_SEL_BIT = 7;
	localparam int COUNT_MSB = 6;
	localparam int COUNT_LSB = 4;
	localparam int DUR_MSB = 3;
	localparam int DUR_LSB = 2;
	localparam int PERIOD_MSB = 1;
	localparam int PERIOD_LSB = 0;

	localparam int NUM_CHAN = 6;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int SAMPLE_BASE_US = 320;
	localparam int CYCLE_BASE_MS = 35;
	localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_US * (CLK_HZ / 1_000_000);
	localparam int CYCLE_BASE_CYC = CYCLE_BASE_MS * (CLK_HZ / 1_000);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_EVAL = 2'b11,
		ST_REST = 2'b10
	} scan_state_e;

endpackage

/* File: standby_sample_accum.sv */
// Sample accumulator for one channel measurement.
// Assumes sample_valid pulses carry signed delta samples of the current channel.
`timescale 1ns/1ns
`default_nettype none
module standby_sample_accum #(
	parameter int SAMPLE_W = 16,
	parameter int SUM_W = 24
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic sample_valid,
	input wire logic signed [SAMPLE_W-1:0] sample,
	output logic signed [SUM_W-1:0] sum_q
);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sum_q <= '0;
		end else if (clk_en) begin
			if (clear) begin
				sum_q <= '0;
			end else if (sample_valid) begin
				sum_q <= sum_q + SUM_W'(sample);
			end
		end
	end

endmodule // standby_sample_accum
`default_nettype wire

/* File: standby_scan_chk.sv */
// Port checker for the standby touch scan block.
// Assumes it is bound into the block and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module standby_scan_chk
	import standby_scan_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic standby_mode,
	input wire logic [2:0] afe_chan,
	input wire logic afe_sample_req,
	input wire logic low_power,
	input wire logic [NUM_CHAN-1:0] touch_status,
	input wire logic touch_event
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_req_pulse: assert property (afe_sample_req |=> !afe_sample_req)
		else $error("request too long");
	a_chan_held: assert property (afe_sample_req |=> $stable(afe_chan))
		else $error("channel moved");
	a_chan_range: assert property (afe_sample_req |-> afe_chan < 3'h6)
		else $error("bad channel");
	a_rest_quiet: assert property (low_power |-> !afe_sample_req)
		else $error("request at rest");
	a_scan_off: assert property (!standby_mode [*3] |-> !afe_sample_req && !touch_event)
		else $error("scan outside standby");
	a_event_set: assert property (touch_event |-> (touch_status != 6'h00) ##1 !touch_event)
		else $error("event without status");
	a_rd_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_gain_bits: assert property (clk_en && reg_rd && reg_addr == ADDR_SENSITIVITY |=>
		reg_rdata[7:3] == 5'h00)
		else $error("gain upper bits set");
endmodule // standby_scan_chk
bind standby_touch_scan standby_scan_chk u_standby_scan_chk (.clk, .rst_n, .clk_en, .reg_addr,
	.reg_rd, .reg_rdata, .standby_mode, .afe_chan, .afe_sample_req, .low_power, .touch_status,
	.touch_event);
`default_nettype wire

/* File: afe_model.sv */
// Front end model answering each sample request after a short or long delay.
// Assumes one request in flight at a time.
`timescale 1ns/1ns
`default_nettype none
module afe_model (
	input wire logic clk,
	input wire logic afe_sample_req,
	input wire logic slow,
	input wire logic signed [15:0] delta,
	output logic afe_sample_valid,
	output logic signed [15:0] afe_sample
);
	int wait_q = 0;
	logic v_q = 1'b0;
	logic signed [15:0] d_q = 16'h5a5a;
	assign afe_sample_valid = v_q;
	assign afe_sample = d_q;
	// Data toggles off the valid cycle so a stale sample can never pass as fresh.
	always @(posedge clk) begin
		v_q <= 1'b0;
		d_q <= ~d_q;
		if (afe_sample_req)
			wait_q <= slow ? 7 : 1;
		else if (wait_q > 0)
			wait_q <= wait_q - 1;
		if (!afe_sample_req && wait_q == 1) begin
			v_q <= 1'b1;
			d_q <= delta;
		end
	end
endmodule // afe_model
`default_nettype wire

/* File: tb_top.sv */
// Bench for the standby touch scan block with a front end model.
// Assumes timing parameters shortened to 4 and 200 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import standby_scan_pkg::*;
();
	logic clk, rst_n, clk_en, reg_wr, reg_rd, standby_mode, slow, afe_sample_req;
	logic afe_sample_valid, low_power, touch_event;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [2:0] afe_chan;
	logic signed [15:0] afe_sample, delta;
	logic [5:0] touch_status;
	logic [15:0] lf = 16'h0e7e;
	logic [5:0] st_exp = 6'h00;
	logic [7:0] msk [4] = '{MASK_CHAN_ENABLE, 8'hff, MASK_SENSITIVITY, MASK_THRESHOLD};
	int err_total = 0;
	int cmp_count = 0;
	int ev_cnt = 0;
	int cnt [6] = '{default: 0};
	standby_touch_scan #(.SAMPLE_BASE_CYCLES(4), .CYCLE_BASE_CYCLES(200)) u_standby_touch_scan (
		.clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.standby_mode, .afe_chan, .afe_sample_req, .afe_sample_valid, .afe_sample,
		.low_power, .touch_status, .touch_event);
	afe_model u_afe_model (.clk, .afe_sample_req, .slow, .delta, .afe_sample_valid, .afe_sample);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (afe_sample_req && afe_chan < 3'h6)
			cnt[afe_chan] <= cnt[afe_chan] + 1;
		if (touch_event)
			ev_cnt <= ev_cnt + 1;
	end
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Samples are constant, so the average equals one sample and the sum scales it.
	function automatic logic hit(input int d, input int c, input logic acc, input int g, input int t);
		return (acc ? d <<< c : d) * (1 << (7 - g)) > t;
	endfunction
	task tally_and_finish();
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk($sformatf("reg %h", a), 16'(e), 16'(reg_rdata));
	endtask
	task wait_lp(input logic lvl, output int n);
		n = 0;
		while (low_power !== lvl && n < 20000) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 20000) begin
			chk("low_power", 16'(lvl), 16'(!lvl));
			tally_and_finish();
		end
	endtask
	task run(input logic [5:0] m, input logic [7:0] cf, input logic [2:0] g, input logic [6:0] t,
		input int d, input logic s, input logic o);
		int a;
		int b;
		int e;
		int base [6];
		logic [5:0] ex;
		wr(ADDR_CHAN_ENABLE, {2'h0, m});
		wr(ADDR_SCAN_CONFIG, cf);
		wr(ADDR_SENSITIVITY, {5'h00, g});
		wr(ADDR_THRESHOLD, {1'b0, t});
		delta <= 16'(d);
		slow <= s;
		base = cnt;
		e = ev_cnt;
		standby_mode <= 1'b1;
		wait_lp(1'b1, a);
		ex = hit(d, cf[6:4], cf[7], g, t) ? m : 6'h00;
		for (int i = 0; i < 6; i++)
			chk("samples", 16'(m[i] ? 1 << cf[6:4] : 0), 16'(cnt[i] - base[i]));
		chk("status", 16'(ex), 16'(touch_status & m));
		st_exp = (st_exp & ~m) | ex;
		rchk(ADDR_TOUCH_STATUS, {2'b00, st_exp});
		chk("event", 16'(ex != 6'h00), 16'(ev_cnt != e));
		wait_lp(1'b0, a);
		wait_lp(1'b1, a);
		wait_lp(1'b0, b);
		if (o)
			chk("rest", 16'h0001, 16'(b));
		else
			chk("period", 16'((cf[1:0] + 1) * 200), 16'(a + b));
		standby_mode <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		standby_mode = 1'b0;
		slow = 1'b0;
		delta = 16'h0000;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rchk(ADDR_CHAN_ENABLE, 8'h00);
		rchk(ADDR_SCAN_CONFIG, 8'h39);
		rchk(ADDR_SENSITIVITY, 8'h02);
		rchk(ADDR_THRESHOLD, 8'h40);
		rchk(8'h45, 8'h00);
		clk_en <= 1'b0;
		wr(ADDR_THRESHOLD, 8'h11);
		clk_en <= 1'b1;
		rchk(ADDR_THRESHOLD, 8'h40);
		for (int k = 0; k < 8; k++) begin
			lf = nxt(lf);
			wr({6'h10, k[1:0]}, k[2] ? lf[7:0] : 8'hff);
			rchk({6'h10, k[1:0]}, (k[2] ? lf[7:0] : 8'hff) & msk[k[1:0]]);
		end
		run(6'h01, 8'h39, 3'h2, 7'h40, 3, 1'b0, 1'b0);
		run(6'h00, 8'h08, 3'h2, 7'h40, 3, 1'b0, 1'b0);
		run(6'h3f, 8'h70, 3'h7, 7'h7f, 1, 1'b1, 1'b1);
		run(6'h24, 8'h92, 3'h4, 7'h10, 1, 1'b0, 1'b0);
		run(6'h12, 8'h03, 3'h0, 7'h00, -1, 1'b1, 1'b0);
		for (int k = 0; k < 6; k++) begin
			lf = nxt(lf);
			run(lf[5:0], {lf[15], 1'b0, lf[8:7], lf[11:10], 2'h1}, lf[14:12], {lf[9:6], lf[2:0]},
				int'(lf[3:0]), 1'b0, 1'b0);
		end
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
